// File: design/asp_regs.svh
// Offsets, field positions, reset values and sample counts of the serial port.
// Assumes an 8-bit register port with a 3-bit address.
`ifndef ASP_REGS_SVH
`define ASP_REGS_SVH
// Register addresses.
`define ASP_A_FMT   3'h0
`define ASP_A_CTL   3'h1
`define ASP_A_STS   3'h2
`define ASP_A_BRG   3'h3
`define ASP_A_BUFL  3'h4
`define ASP_A_BUFH  3'h5
// Format fields; bits 1:0 give length 7, 8 or 9.
`define ASP_M_STB   3
`define ASP_M_PSEL  4
`define ASP_M_PEN   5
`define ASP_M_CLK   6
// Control fields.
`define ASP_C_TEN   0
`define ASP_C_REN   1
`define ASP_C_TIN   2
`define ASP_C_RIN   3
`define ASP_C_TIS   4
`define ASP_C_CTS   5
`define ASP_C_RTS   6
`define ASP_CTL_WM  8'h73
// Status fields.
`define ASP_S_TBE   0
`define ASP_S_TCM   1
`define ASP_S_RBF   2
`define ASP_S_OER   3
`define ASP_S_FER   4
`define ASP_S_PER   5
`define ASP_S_SER   6
// Reset values.
`define ASP_FMT_RST 8'h01
// Positions within one bit time of 16 samples.
`define ASP_T_CHK   4'h1
`define ASP_T_SA    4'h7
`define ASP_T_SB    4'h8
`define ASP_T_SC    4'h9
`define ASP_T_LAST  4'hf
`endif

// File: design/asp_pkg.sv
// Types of the serial port core.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package asp_pkg;
   typedef enum logic [1:0] {ASP_RX_IDLE, ASP_RX_START, ASP_RX_BITS} asp_rx_t;
   typedef struct packed {
      logic [7:0]  fmt;
      logic [7:0]  ctl;
      logic [7:0]  brg;
      logic [7:0]  brg_cnt;
      logic [8:0]  tx_buf;
      logic        transmit_buffer_empty_flag;
      logic        transmit_complete_flag;
      logic        tx_busy;
      logic        txd;
      logic [12:0] tx_sh;
      logic [3:0]  tx_tick;
      logic [3:0]  tx_idx;
      logic [3:0]  tx_last;
      asp_rx_t     rx_st;
      logic        rx_prev;
      logic [3:0]  rx_tick;
      logic [3:0]  rx_idx;
      logic [1:0]  rx_lows;
      logic [12:0] rx_bits;
      logic [8:0]  rx_buf;
      logic        receive_full_flag;
      logic        overrun_flag;
      logic        framing_error_flag;
      logic        parity_error_flag;
      logic        error_summary_flag;
      logic        err_unread;
      logic        pend;
      logic        p_fer;
      logic        p_per;
      logic [8:0]  p_data;
      logic [7:0]  rd_data;
      logic        tx_irq;
      logic        rxf_irq;
      logic        rxe_irq;
      logic        rts_n;
   } asp_state_t;
endpackage
`default_nettype wire

// File: design/asp_core.sv
// Serial port core: one asynchronous transmitter and receiver channel.
// Assumes synchronous inputs and a one-cycle strobe register port.
//
// Contract
// RULE1: Status is read-only; writes ignored, top bit reads zero.
// RULE2: Error summary sets on erroneous reception; clears on status read or init.
// RULE3: Reception completing during a status read updates flags after that read.
// RULE4: Overrun sets if buffer unread or prior error unread; clears likewise.
// RULE5: Framing error sets when a stop bit, either of two, is zero.
// RULE6: Parity error sets on mismatch with selected sense when parity enabled.
// RULE7: Receive full sets on good last stop bit; clears on low read or init.
// RULE8: Transmit complete sets when last bit leaves and nothing can follow.
// RULE9: Transmit complete clears when a new character starts.
// RULE10: Buffer empty sets on load to shifter or init; clears on low write.
// RULE11: Transmit init forces buffer empty and transmit complete both set.
// RULE12: Control bits 0, 4, 5 are transmit enable, irq source, handshake.
// RULE13: Control bits 1 and 6 are receive enable and request-to-send enable.
// RULE14: Software programs the 0 to 255 divisor before enabling.
// RULE15: For nine bits software writes the high byte before the low byte.
// RULE16: Idle shifter and clear-to-send allow load, clear complete, set empty.
// RULE17: Frame is start, data least bit first, optional parity, stop bits.
// RULE18: Dropping enable or clear-to-send mid character does not abort it.
// RULE19: Start needs two low samples then a three-sample mid-bit majority.
// RULE20: Bits shift in least first, each decided by three-sample majority.
// RULE21: Good character loads buffer and full irq; bad sets errors and irq.
// RULE22: Transmit irq follows buffer empty or transmit complete per select.
// RULE23: Format register drives length, parity, stops and clock on both paths.
//
// Decided for this implementation: the strobed register port and the register offsets.
`include "asp_regs.svh"
`default_nettype none
module asp_core
   import asp_pkg::*;
(
   input  wire logic       sys_clk_in,      // System clock, 10 MHz.
   input  wire logic       rst_in,          // Asynchronous reset, high.
   input  wire logic [2:0] addr_in,         // Register address.
   input  wire logic [7:0] wdata_in,        // Write data.
   input  wire logic       wr_in,           // Write strobe.
   input  wire logic       rd_in,           // Read strobe.
   output logic      [7:0] rdata_out,       // Read data, cycle after strobe.
   input  wire logic       rxd_in,          // Serial receive line.
   input  wire logic       cts_n_in,        // Clear to send, low active.
   input  wire logic       ext_tick_in,     // Alternate clock source tick.
   output logic            txd_out,         // Serial transmit line.
   output logic            rts_n_out,       // Request to send, low active.
   output logic            tx_irq_out,      // Transmit interrupt pulse.
   output logic            rx_full_irq_out, // Receive full interrupt pulse.
   output logic            rx_err_irq_out   // Receive error interrupt pulse.
);

   // ****************************************
   // Helper functions
   // ****************************************

   // Number of data bits for the format.
   function automatic logic [3:0] asp_dl(input logic [7:0] f);
      if (f[1:0] == 2'h0) begin
         return 4'h7;
      end else if (f[1:0] == 2'h1) begin
         return 4'h8;
      end
      return 4'h9;
   endfunction

   // Frame length in bits, start bit included.
   function automatic logic [3:0] asp_nb(input logic [7:0] f);
      return 4'h2 + asp_dl(f) + {3'h0, f[`ASP_M_PEN]} + {3'h0, f[`ASP_M_STB]};
   endfunction

   // Parity bit to send for the data; odd sense when odd is set.
   function automatic logic asp_par(input logic [8:0] d, input logic [3:0] dl, input logic odd);
      logic p;
      p = odd;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(dl)) begin
            p = p ^ d[i];
         end
      end
      return p;
   endfunction

   // Full transmit frame, idle-high bits beyond its end.
   function automatic logic [12:0] asp_frame(input logic [8:0] d, input logic [7:0] f);
      logic [12:0] r;
      logic [3:0]  dl;
      r = 13'h1fff;
      dl = asp_dl(f);
      r[0] = 1'b0;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(dl)) begin
            r[i+1] = d[i];
         end
      end
      if (f[`ASP_M_PEN]) begin
         r[dl+4'h1] = asp_par(d, dl, f[`ASP_M_PSEL]);
      end
      return r;
   endfunction

   // Data field of a received frame, unused high bits zero.
   function automatic logic [8:0] asp_rxdata(input logic [12:0] b, input logic [3:0] dl);
      logic [8:0] d;
      d = 9'h000;
      for (int i = 0; i < 9; i++) begin
         if (i < int'(dl)) begin
            d[i] = b[i+1];
         end
      end
      return d;
   endfunction

   // ****************************************
   // State and events
   // ****************************************

   localparam asp_state_t ASP_RST = '{default: '0, fmt: `ASP_FMT_RST, transmit_buffer_empty_flag: 1'b1, transmit_complete_flag: 1'b1,
                                      txd: 1'b1, rx_prev: 1'b1, rts_n: 1'b1, rx_st: ASP_RX_IDLE};

   asp_state_t  s;
   asp_state_t  n;
   logic        src;
   logic        tick;
   logic        wr_low;
   logic        sts_rd;
   logic        low_rd;
   logic        transmit_initialise;
   logic        receive_initialise;
   logic        can;
   logic        tx_start;
   logic        tx_done;
   logic        smp;
   logic [1:0]  lows_n;
   logic        bitv;
   logic        rx_comp;
   logic        ev;
   logic [3:0]  dl;
   logic [3:0]  pen4;
   logic [3:0]  rx_last;
   logic [12:0] rb;
   logic [7:0]  sts;
   logic [8:0]  c_data;
   logic        c_fer;
   logic        c_per;
   logic        v_fer;
   logic        v_per;
   logic        v_oer;
   logic [8:0]  v_data;

   // ****************************************
   // Next state
   // ****************************************

   // All behaviour is decided here and registered below.
   always_comb begin
      n = s;
      n.tx_irq = 1'b0;
      n.rxf_irq = 1'b0;
      n.rxe_irq = 1'b0;
      dl = asp_dl(s.fmt);  // RULE23
      pen4 = {3'h0, s.fmt[`ASP_M_PEN]};
      rx_last = asp_nb(s.fmt) - 4'h1;
      wr_low = wr_in && (addr_in == `ASP_A_BUFL);
      sts_rd = rd_in && (addr_in == `ASP_A_STS);
      low_rd = rd_in && (addr_in == `ASP_A_BUFL);
      transmit_initialise = wr_in && (addr_in == `ASP_A_CTL) && wdata_in[`ASP_C_TIN];
      receive_initialise = wr_in && (addr_in == `ASP_A_CTL) && wdata_in[`ASP_C_RIN];

      // Sample clock at 16 times the baud rate, divide by divisor plus one.
      src = s.fmt[`ASP_M_CLK] ? ext_tick_in : 1'b1;  // RULE23
      tick = src && (s.brg_cnt == 8'h00);
      if (src) begin
         n.brg_cnt = tick ? s.brg : s.brg_cnt - 8'h01;
      end

      // Status image; the top bit is never driven.
      sts = 8'h00;  // RULE1
      sts[`ASP_S_TBE] = s.transmit_buffer_empty_flag;
      sts[`ASP_S_TCM] = s.transmit_complete_flag;
      sts[`ASP_S_RBF] = s.receive_full_flag;
      sts[`ASP_S_OER] = s.overrun_flag;
      sts[`ASP_S_FER] = s.framing_error_flag;
      sts[`ASP_S_PER] = s.parity_error_flag;
      sts[`ASP_S_SER] = s.error_summary_flag;

      // Read data stands only in the cycle after the strobe.
      n.rd_data = 8'h00;
      if (rd_in) begin
         case (addr_in)
            `ASP_A_FMT:  n.rd_data = s.fmt;
            `ASP_A_CTL:  n.rd_data = s.ctl;
            `ASP_A_STS:  n.rd_data = sts;
            `ASP_A_BRG:  n.rd_data = s.brg;
            `ASP_A_BUFL: n.rd_data = s.rx_buf[7:0];
            `ASP_A_BUFH: n.rd_data = {7'h00, s.rx_buf[8]};
            default:     n.rd_data = 8'h00;
         endcase
      end

      // Writes; the init bits act once and read back as zero.
      if (wr_in) begin
         case (addr_in)
            `ASP_A_FMT:  n.fmt = wdata_in;
            `ASP_A_CTL:  n.ctl = wdata_in & `ASP_CTL_WM;  // RULE12 RULE13
            `ASP_A_BRG:  n.brg = wdata_in;
            `ASP_A_BUFH: n.tx_buf[8] = wdata_in[0];
            `ASP_A_BUFL: begin
               n.tx_buf[7:0] = wdata_in;
               n.transmit_buffer_empty_flag = 1'b0;  // RULE10
            end
            default:     n.brg = s.brg;  // RULE1
         endcase
      end

      // ****************************************
      // Transmitter
      // ****************************************

      // A load is held off in the low-byte write cycle, so the new byte
      // never races the empty flag.
      tx_done = s.tx_busy && tick && (s.tx_tick == `ASP_T_LAST) && (s.tx_idx == s.tx_last);
      can = !s.transmit_buffer_empty_flag && s.ctl[`ASP_C_TEN] && (!s.ctl[`ASP_C_CTS] || !cts_n_in) && !wr_low;
      tx_start = can && (!s.tx_busy || tx_done);  // RULE16
      if (s.tx_busy && tick) begin
         n.tx_tick = s.tx_tick + 4'h1;
         if (s.tx_tick == `ASP_T_LAST) begin
            n.tx_idx = s.tx_idx + 4'h1;
            n.tx_sh = {1'b1, s.tx_sh[12:1]};  // RULE17
            n.txd = s.tx_sh[1];
         end
      end
      // Only the bit count or a transmit init ends a character, never enable or handshake.
      if (tx_done) begin  // RULE18
         n.tx_busy = 1'b0;
         n.txd = 1'b1;
         if (!tx_start) begin
            n.transmit_complete_flag = 1'b1;  // RULE8
         end
      end
      if (tx_start) begin
         n.tx_sh = asp_frame(s.tx_buf, s.fmt);  // RULE17 RULE23
         n.txd = 1'b0;
         n.tx_busy = 1'b1;
         n.tx_idx = 4'h0;
         n.tx_tick = 4'h0;
         n.tx_last = asp_nb(s.fmt) - 4'h1;
         n.transmit_complete_flag = 1'b0;  // RULE9
         n.transmit_buffer_empty_flag = 1'b1;  // RULE10
      end
      if (transmit_initialise) begin  // RULE11
         n.tx_busy = 1'b0;
         n.txd = 1'b1;
         n.transmit_buffer_empty_flag = 1'b1;
         n.transmit_complete_flag = 1'b1;
      end
      n.tx_irq = s.ctl[`ASP_C_TIS] ? (n.transmit_complete_flag && !s.transmit_complete_flag) : (n.transmit_buffer_empty_flag && !s.transmit_buffer_empty_flag);  // RULE22

      // ****************************************
      // Receiver
      // ****************************************

      // Three samples at positions 7, 8 and 9 vote; low count below two is a one.
      smp = tick && ((s.rx_tick == `ASP_T_SA) || (s.rx_tick == `ASP_T_SB) || (s.rx_tick == `ASP_T_SC));
      lows_n = smp ? s.rx_lows + {1'b0, !rxd_in} : s.rx_lows;
      bitv = (lows_n < 2'h2);  // RULE20
      rx_comp = 1'b0;
      rb = s.rx_bits;
      rb[s.rx_idx] = bitv;
      unique case (s.rx_st)
         ASP_RX_IDLE: begin
            if (tick) begin
               n.rx_prev = rxd_in;
               if (s.ctl[`ASP_C_REN] && s.rx_prev && !rxd_in) begin  // RULE19
                  n.rx_st = ASP_RX_START;
                  n.rx_tick = 4'h0;
                  n.rx_idx = 4'h0;
                  n.rx_lows = 2'h0;
               end
            end
         end
         ASP_RX_START, ASP_RX_BITS: begin
            if (tick) begin
               n.rx_tick = s.rx_tick + 4'h1;
               n.rx_lows = lows_n;
               if ((s.rx_st == ASP_RX_START) && (s.rx_tick == `ASP_T_CHK) && rxd_in) begin
                  n.rx_st = ASP_RX_IDLE;  // RULE19
               end
               if (s.rx_tick == `ASP_T_SC) begin
                  if (s.rx_st == ASP_RX_START) begin
                     n.rx_st = bitv ? ASP_RX_IDLE : ASP_RX_BITS;  // RULE19
                  end else begin
                     n.rx_bits = rb;  // RULE20
                     if (s.rx_idx == rx_last) begin
                        rx_comp = 1'b1;
                        n.rx_st = ASP_RX_IDLE;
                        n.rx_prev = bitv;
                     end
                  end
               end
               if (s.rx_tick == `ASP_T_LAST) begin
                  n.rx_idx = s.rx_idx + 4'h1;
                  n.rx_lows = 2'h0;
               end
            end
         end
         default: n.rx_st = ASP_RX_IDLE;
      endcase

      // Error checks of a finished frame.
      c_data = asp_rxdata(rb, dl);
      c_fer = !rb[dl+4'h1+pen4] || (s.fmt[`ASP_M_STB] && !rb[dl+4'h2+pen4]);  // RULE5
      c_per = s.fmt[`ASP_M_PEN] && (rb[dl+4'h1] != asp_par(c_data, dl, s.fmt[`ASP_M_PSEL]));  // RULE6
      ev = rx_comp || s.pend;
      v_fer = rx_comp ? c_fer : s.p_fer;
      v_per = rx_comp ? c_per : s.p_per;
      v_data = rx_comp ? c_data : s.p_data;
      v_oer = s.receive_full_flag || s.err_unread;  // RULE4

      // Read clears come first so that a hardware set wins; receive init comes last and wins.
      if (sts_rd) begin  // RULE2 RULE4
         n.overrun_flag = 1'b0;
         n.framing_error_flag = 1'b0;
         n.parity_error_flag = 1'b0;
         n.error_summary_flag = 1'b0;
         n.err_unread = 1'b0;
      end
      if (low_rd) begin
         n.receive_full_flag = 1'b0;  // RULE7
      end
      // A result that meets a status read waits until the read is over.
      if (ev && sts_rd) begin  // RULE3
         n.pend = 1'b1;
         n.p_fer = v_fer;
         n.p_per = v_per;
         n.p_data = v_data;
      end else if (ev) begin
         n.pend = 1'b0;
         if (v_oer || v_fer || v_per) begin  // RULE21
            n.overrun_flag = n.overrun_flag || v_oer;
            n.framing_error_flag = n.framing_error_flag || v_fer;
            n.parity_error_flag = n.parity_error_flag || v_per;
            n.error_summary_flag = 1'b1;  // RULE2
            n.err_unread = 1'b1;
            n.rxe_irq = 1'b1;
         end else begin
            n.rx_buf = v_data;  // RULE21
            n.receive_full_flag = 1'b1;  // RULE7
            n.rxf_irq = 1'b1;
         end
      end
      if (receive_initialise) begin  // RULE2 RULE4 RULE7
         n.rx_st = ASP_RX_IDLE;
         n.rx_prev = 1'b1;
         n.pend = 1'b0;
         n.receive_full_flag = 1'b0;
         n.overrun_flag = 1'b0;
         n.framing_error_flag = 1'b0;
         n.parity_error_flag = 1'b0;
         n.error_summary_flag = 1'b0;
         n.err_unread = 1'b0;
      end
      // Request to send is asserted only while the receiver waits idle.
      n.rts_n = !(n.ctl[`ASP_C_RTS] && n.ctl[`ASP_C_REN] && (n.rx_st == ASP_RX_IDLE));  // RULE13
   end

   // ****************************************
   // State register and outputs
   // ****************************************

   // Single register for the whole state.
   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         s <= ASP_RST;
      end else begin
         s <= n;
      end
   end

   // Outputs come straight from the state register.
   assign rdata_out = s.rd_data;
   assign txd_out = s.txd;
   assign rts_n_out = s.rts_n;
   assign tx_irq_out = s.tx_irq;
   assign rx_full_irq_out = s.rxf_irq;
   assign rx_err_irq_out = s.rxe_irq;

   // ****************************************
   // Assertions
   // ****************************************

   default clocking @(posedge sys_clk_in);
   endclocking
   default disable iff (rst_in);

   property p_sts_msb;
      sts_rd |=> (rdata_out[7] == 1'b0) && (rdata_out[6] == $past(s.error_summary_flag));
   endproperty
   a_sts_msb: assert property (p_sts_msb) else $error("status read image wrong"); // RULE1

   property p_ser_clr;
      sts_rd |=> !s.error_summary_flag && !s.overrun_flag && !s.framing_error_flag && !s.parity_error_flag;
   endproperty
   a_ser_clr: assert property (p_ser_clr) else $error("error flags not cleared by status read"); // RULE2

   property p_hold;
      sts_rd && rx_comp && !receive_initialise |=> s.pend && !rx_err_irq_out && !rx_full_irq_out;
   endproperty
   a_hold: assert property (p_hold) else $error("result not held during status read"); // RULE3

   property p_release;
      s.pend && !sts_rd && !receive_initialise |=> !s.pend && (rx_err_irq_out || rx_full_irq_out);
   endproperty
   a_release: assert property (p_release) else $error("held result not applied"); // RULE3

   property p_rbf_clr;
      low_rd && !ev |=> !s.receive_full_flag;
   endproperty
   a_rbf_clr: assert property (p_rbf_clr) else $error("full flag not cleared by low read"); // RULE7

   property p_tin;
      transmit_initialise |=> s.transmit_buffer_empty_flag && s.transmit_complete_flag && txd_out && !s.tx_busy;
   endproperty
   a_tin: assert property (p_tin) else $error("transmit init did not set status"); // RULE11

   property p_start;
      tx_start && !transmit_initialise |=> !s.transmit_complete_flag && s.transmit_buffer_empty_flag && !txd_out && s.tx_busy;
   endproperty
   a_start: assert property (p_start) else $error("character start flags wrong"); // RULE9

   property p_tbe_clr;
      wr_low && !transmit_initialise |=> !s.transmit_buffer_empty_flag;
   endproperty
   a_tbe_clr: assert property (p_tbe_clr) else $error("empty flag not cleared by low write"); // RULE10

   property p_no_abort;
      s.tx_busy && !tx_done && !transmit_initialise |=> s.tx_busy;
   endproperty
   a_no_abort: assert property (p_no_abort) else $error("character aborted early"); // RULE18

   property p_chk;
      (s.rx_st == ASP_RX_START) && tick && (s.rx_tick == `ASP_T_CHK) && rxd_in && !receive_initialise
         |=> (s.rx_st == ASP_RX_IDLE);
   endproperty
   a_chk: assert property (p_chk) else $error("short start pulse accepted"); // RULE19

   property p_err_irq;
      rx_err_irq_out |-> s.error_summary_flag && !$past(s.pend && sts_rd);
   endproperty
   a_err_irq: assert property (p_err_irq) else $error("error irq without summary flag"); // RULE21

   c_tx_done: cover property (tx_done);
   c_rx_ok: cover property (rx_full_irq_out);
   c_rx_err: cover property (rx_err_irq_out);
   c_hold: cover property (sts_rd && rx_comp);

endmodule
`default_nettype wire

// File: tb/asp_remote.sv
// Remote serial device model: drives frames onto the core's receive line and decodes the transmit line.
// Assumes a divisor of 0 and the internal source, so one bit lasts 16 system clocks.
`default_nettype none
module asp_remote (
   input  wire logic sys_clk_in, // System clock.
   input  wire logic txd_in,     // Line from the core.
   output logic      rxd_out,    // Line into the core.
   output logic      cts_n_out   // Clear to send, low active.
);
   timeunit 1ns;
   timeprecision 1ns;
   // Line idles high; clear to send is withheld until the bench grants it.
   initial begin
      rxd_out   = 1'b1;
      cts_n_out = 1'b1;
   end
   // Sends n bits, bit 0 first, one bit time each, then returns the line to idle.
   task automatic send_frame(input logic [12:0] bits, input int n);
      for (int i = 0; i < n; i++) begin
         @(posedge sys_clk_in);
         rxd_out <= bits[i];
         repeat (15) @(posedge sys_clk_in);
      end
      @(posedge sys_clk_in);
      rxd_out <= 1'b1;
   endtask
   // Samples each bit at its centre, start bit first, so the caller sees the wire order.
   task automatic get_frame(input int n, output logic [12:0] bits);
      bits = '0;
      wait (txd_in === 1'b0);
      repeat (8) @(posedge sys_clk_in);
      for (int i = 0; i < n; i++) begin
         bits[i] = txd_in;
         repeat (16) @(posedge sys_clk_in);
      end
   endtask
endmodule
`default_nettype wire

// File: tb/async_serial_port_core_test.sv
// Self-checking bench of the serial port core: register tasks plus a remote line model.
// Assumes asp_pkg, asp_regs.svh and asp_core are compiled first.
`include "asp_regs.svh"
`default_nettype none
module async_serial_port_core_test;
   timeunit 1ns;
   timeprecision 1ns;
   logic        sys_clk_in = 1'b0;
   logic        rst_in = 1'b1;
   logic [2:0]  addr_in = 3'h0;
   logic [7:0]  wdata_in = 8'h00;
   logic        wr_in = 1'b0;
   logic        rd_in = 1'b0;
   logic [7:0]  rdata_out;
   logic        rxd, cts_n, txd, rts_n, tx_irq, rxf_irq, rxe_irq;
   logic        ext_tick = 1'b1;
   logic [12:0] fr;
   int          errors = 0, checked = 0, cycles = 0, n_full = 0, n_err = 0, n_tx = 0;

   asp_core DUT (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .addr_in(addr_in), .wdata_in(wdata_in),
      .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .rxd_in(rxd), .cts_n_in(cts_n),
      .ext_tick_in(ext_tick), .txd_out(txd), .rts_n_out(rts_n), .tx_irq_out(tx_irq),
      .rx_full_irq_out(rxf_irq), .rx_err_irq_out(rxe_irq));
   asp_remote far (.sys_clk_in(sys_clk_in), .txd_in(txd), .rxd_out(rxd), .cts_n_out(cts_n));

   // 10 MHz clock.
   always #50 sys_clk_in = ~sys_clk_in;

   // Interrupt pulses last one cycle, so counting them per edge gives exact totals.
   always @(posedge sys_clk_in) begin
      n_full <= n_full + (rxf_irq === 1'b1);
      n_err  <= n_err + (rxe_irq === 1'b1);
      n_tx   <= n_tx + (tx_irq === 1'b1);
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         errors++;
         tally_and_finish();
      end
   end

   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      checked++;
      if (seen !== exp) begin
         errors++;
         $display("ERROR at %0t: saw %h, expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      @(posedge sys_clk_in);
      addr_in  <= a;
      wdata_in <= d;
      wr_in    <= 1'b1;
      @(posedge sys_clk_in);
      wr_in <= 1'b0;
   endtask
   // Read data stand only in the cycle after the strobe edge, so sample just after it.
   task automatic rd(input logic [2:0] a, input logic [7:0] exp);
      @(posedge sys_clk_in);
      addr_in <= a;
      rd_in   <= 1'b1;
      @(posedge sys_clk_in);
      rd_in <= 1'b0;
      #1 check(rdata_out, exp);
   endtask
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      rd(`ASP_A_STS, 8'h03);
      rd(`ASP_A_FMT, 8'h01);
      wr(`ASP_A_STS, 8'hff);
      rd(`ASP_A_STS, 8'h03);
      wr(`ASP_A_BRG, 8'h00);
      wr(`ASP_A_CTL, 8'h01);
      $display("registers done");
      // Frame shape and flags while and after shifting.
      wr(`ASP_A_BUFL, 8'ha5);
      fork
         far.get_frame(10, fr);
         rd(`ASP_A_STS, 8'h01);
      join
      check(fr, {3'h0, 1'b1, 8'ha5, 1'b0});
      rd(`ASP_A_STS, 8'h03);
      // Even parity; enable dropped mid character must not cut it short.
      wr(`ASP_A_FMT, 8'h21);
      wr(`ASP_A_BUFL, 8'h07);
      fork
         far.get_frame(11, fr);
         begin
            repeat (40) @(posedge sys_clk_in);
            wr(`ASP_A_CTL, 8'h00);
         end
      join
      check(fr, {2'h0, 1'b1, 1'b1, 8'h07, 1'b0});
      rd(`ASP_A_STS, 8'h03);
      $display("transmit done");
      // Handshake holds the load; init restores the transmit flags.
      wr(`ASP_A_FMT, 8'h01);
      wr(`ASP_A_CTL, 8'h21);
      wr(`ASP_A_BUFL, 8'h11);
      repeat (20) @(posedge sys_clk_in);
      check(txd, 1'b1);
      rd(`ASP_A_STS, 8'h02);
      wr(`ASP_A_CTL, 8'h25);
      rd(`ASP_A_STS, 8'h03);
      wr(`ASP_A_BUFL, 8'h5a);
      far.cts_n_out <= 1'b0;
      far.get_frame(10, fr);
      check(fr, {3'h0, 1'b1, 8'h5a, 1'b0});
      // Nine-bit character on the external tick with the completion irq selected.
      // With no external tick the start bit must stall, so a wrong source shows up as data bits.
      wr(`ASP_A_CTL, 8'h31);
      ext_tick <= 1'b0;
      wr(`ASP_A_FMT, 8'h42);
      wr(`ASP_A_BUFH, 8'h01);
      wr(`ASP_A_BUFL, 8'h2d);
      repeat (40) @(posedge sys_clk_in);
      check(txd, 1'b0);
      check(13'(n_tx), 13'd4);
      ext_tick <= 1'b1;
      far.get_frame(11, fr);
      check(fr, {2'h0, 1'b1, 9'h12d, 1'b0});
      check(13'(n_tx), 13'd5);
      wr(`ASP_A_FMT, 8'h01);
      $display("handshake done");
      // Good character, then an overrun.
      wr(`ASP_A_CTL, 8'h42);
      #1 check(rts_n, 1'b0);
      far.send_frame({3'h7, 1'b1, 8'h3c, 1'b0}, 10);
      rd(`ASP_A_STS, 8'h07);
      rd(`ASP_A_BUFL, 8'h3c);
      rd(`ASP_A_STS, 8'h03);
      far.send_frame({3'h7, 1'b1, 8'h81, 1'b0}, 10);
      far.send_frame({3'h7, 1'b1, 8'h42, 1'b0}, 10);
      rd(`ASP_A_STS, 8'h4f);
      rd(`ASP_A_STS, 8'h07);
      rd(`ASP_A_BUFL, 8'h81);
      // Second of two stop bits low, then a wrong even parity bit.
      wr(`ASP_A_FMT, 8'h09);
      far.send_frame({2'h0, 1'b0, 1'b1, 8'h66, 1'b0}, 11);
      rd(`ASP_A_STS, 8'h53);
      wr(`ASP_A_FMT, 8'h21);
      far.send_frame({2'h3, 1'b1, 1'b0, 8'h07, 1'b0}, 11);
      rd(`ASP_A_STS, 8'h63);
      // A one-cycle glitch is not a start bit.
      @(posedge sys_clk_in);
      far.rxd_out <= 1'b0;
      @(posedge sys_clk_in);
      far.rxd_out <= 1'b1;
      repeat (200) @(posedge sys_clk_in);
      rd(`ASP_A_STS, 8'h03);
      // A frame that completes in the status read cycle is applied one cycle later.
      fork
         far.send_frame({2'h3, 1'b1, 1'b0, 8'h55, 1'b0}, 11);
         begin
            repeat (170) @(posedge sys_clk_in);
            rd(`ASP_A_STS, 8'h03);
         end
      join
      rd(`ASP_A_STS, 8'h07);
      check(13'(n_full), 13'd3);
      check(13'(n_err), 13'd3);
      check(13'(n_tx), 13'd5);
      $display("receive done");
      tally_and_finish();
   end
endmodule
`default_nettype wire
